/* File: hdl/lcd_host_register_access.sv */
/*
  Host register access of a character display controller: command and
  data transfer registers, busy indication, address counter, display
  RAM, pattern RAM and pattern ROM with a dot scan-out path.
  Assumes host pins are asynchronous to clk_sys; configuration, scan and
  ROM load inputs come from logic on clk_sys.
*/
// Contract
// - two 8-bit host registers: command, data
// - command register never readable by host
// - data write goes to selected RAM
// - address command preloads data register from RAM
// - after data read, fetch next address
// - busy high, further instructions refused
// - status read puts busy on bit seven
// - address command loads counter, selects RAM
// - counter steps by one after access
// - status read puts counter on bits 0-6
// - select low, write: command write
// - select high: data write or read
// - display RAM has 80 byte locations
// - second line address range not contiguous
// - display shift moves shown addresses
// - pattern ROM: 192 character patterns
// - pattern RAM: eight or four user patterns
// - reserved codes display pattern RAM
// - ROM address: code high, row low
// - ROM dots on bits 4-0 only
// - 4-bit bus uses bits 7-4 only
`timescale 1ns/100ps
module lcd_host_register_access
  import lcd_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // host pins
  input wire host_pins_t hostPins,
  output logic [7:0] dataOut,
  output logic [7:0] dataOe,
  // configuration
  input wire logic fourBitBus,
  input wire logic twoLine,
  input wire logic decrementMode,
  input wire logic tallFont,
  // dot scan
  input wire logic scanLine,
  input wire logic [6:0] scanCol,
  input wire logic [3:0] scanRow,
  output logic [DOT_W-1:0] dotRow,
  // pattern ROM content load
  input wire logic romLoadWe,
  input wire logic [ROM_AW-1:0] romLoadAddr,
  input wire logic [7:0] romLoadData
);

  host_pins_t pinSync1_reg, pinSync2_reg;
  logic enPrev_reg;
  logic latchedRs_reg, latchedRs_next, latchedRw_reg, latchedRw_next;
  logic [7:0] latchedData_reg, latchedData_next;
  logic nibblePhase_reg, nibblePhase_next;
  logic [3:0] nibbleHigh_reg, nibbleHigh_next;
  op_state_t opState_reg, opState_next;
  logic busy_reg, busy_next;
  logic [6:0] ac_reg, ac_next;
  logic selPattern_reg, selPattern_next;
  logic [7:0] dataReg_reg, dataReg_next;
  logic [7:0] cmdReg_reg, cmdReg_next;
  logic [6:0] shift_reg, shift_next;
  logic [6:0] clearIdx_reg, clearIdx_next;
  logic [HOLD_W-1:0] hold_reg, hold_next;
  logic [7:0] dataOut_next, dataOe_next;
  logic strobeRise, strobeFall, byteDone;
  logic [7:0] hostByte, readValue;
  logic [6:0] lineLen, acPhys, dispAddrA;
  logic dispWe, patWe;
  logic [7:0] memWdata, dispRdA, patRdA, dispRdB, patRdB, romRdB;
  logic [6:0] scanPos, scanAddr;
  logic [7:0] scanSum;
  logic [3:0] scanRow1_reg;
  logic codeIsPat2_reg, codeIsPat2_next;
  logic [DOT_W-1:0] dotRow_next;
  logic [PATTERN_AW-1:0] patAddrB;
  logic [ROM_AW-1:0] romAddrB;

  function automatic logic [6:0] stepAc(input logic [6:0] a, input logic pat, input logic dn, input logic two);
    logic [6:0] r;
    if (pat) begin
      r = dn ? {1'b0, a[5:0] - 6'h01} : {1'b0, a[5:0] + 6'h01};
    end else if (!dn) begin
      if (two && a == LINE1_END_TWO) r = LINE2_START;
      else if (two && a == LINE2_END) r = 7'h00;
      else if (!two && a == LINE1_END_ONE) r = 7'h00;
      else r = a + 7'h01;
    end else begin
      if (two && a == LINE2_START) r = LINE1_END_TWO;
      else if (two && a == 7'h00) r = LINE2_END;
      else if (!two && a == 7'h00) r = LINE1_END_ONE;
      else r = a - 7'h01;
    end
    return r;
  endfunction : stepAc

  // pins reach logic only through two flops
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pinSync1_reg <= '0;
      pinSync2_reg <= '0;
      enPrev_reg <= 1'b0;
    end else begin
      pinSync1_reg <= hostPins;
      pinSync2_reg <= pinSync1_reg;
      enPrev_reg <= pinSync2_reg.enable;
    end
  end

  assign strobeRise = pinSync2_reg.enable && !enPrev_reg;
  assign strobeFall = !pinSync2_reg.enable && enPrev_reg;
  assign lineLen = twoLine ? LINE_LEN_TWO : LINE_LEN_ONE;
  assign acPhys = (twoLine && ac_reg >= LINE2_START) ? 7'(ac_reg - LINE2_START + LINE2_PHYS_BASE) : ac_reg;
  assign readValue = pinSync2_reg.regSelect ? dataReg_reg : {busy_reg, ac_reg};

  // strobe capture and nibble pairing
  always_comb begin
    latchedRs_next = latchedRs_reg;
    latchedRw_next = latchedRw_reg;
    latchedData_next = latchedData_reg;
    nibblePhase_next = nibblePhase_reg;
    nibbleHigh_next = nibbleHigh_reg;
    byteDone = 1'b0;
    hostByte = latchedData_reg;
    if (strobeRise) begin
      latchedRs_next = pinSync2_reg.regSelect;
      latchedRw_next = pinSync2_reg.readWrite;
    end
    // data is taken while enable is still high, ahead of the hold edge
    if (pinSync2_reg.enable) begin
      latchedData_next = pinSync2_reg.data;
    end
    if (strobeFall) begin
      if (fourBitBus) begin
        if (!nibblePhase_reg) begin
          nibbleHigh_next = latchedData_reg[7:4];
          nibblePhase_next = 1'b1;
        end else begin
          hostByte = {nibbleHigh_reg, latchedData_reg[7:4]};
          byteDone = 1'b1;
          nibblePhase_next = 1'b0;
        end
      end else begin
        byteDone = 1'b1;
        nibblePhase_next = 1'b0;
      end
    end
  end

  // internal operations
  always_comb begin
    opState_next = opState_reg;
    busy_next = busy_reg;
    ac_next = ac_reg;
    selPattern_next = selPattern_reg;
    dataReg_next = dataReg_reg;
    cmdReg_next = cmdReg_reg;
    shift_next = shift_reg;
    clearIdx_next = clearIdx_reg;
    hold_next = hold_reg;
    dispWe = 1'b0;
    patWe = 1'b0;
    memWdata = dataReg_reg;
    dispAddrA = acPhys;
    case (opState_reg)
      OP_IDLE: begin
        if (byteDone && !latchedRs_reg && !latchedRw_reg) begin
          cmdReg_next = hostByte;
          busy_next = 1'b1;
          if (hostByte == CMD_CLEAR) begin
            clearIdx_next = 7'h00;
            opState_next = OP_CLEAR;
          end else if (hostByte[CMD_DISP_ADDR_BIT]) begin
            ac_next = hostByte[6:0];
            selPattern_next = 1'b0;
            opState_next = OP_FETCH;
          end else if ((hostByte & CMD_PAT_ADDR_MASK) == CMD_PAT_ADDR_CODE) begin
            ac_next = {1'b0, hostByte[5:0]};
            selPattern_next = 1'b1;
            opState_next = OP_FETCH;
          end else if ((hostByte & CMD_SHIFT_MASK) == CMD_SHIFT_CODE) begin
            if (hostByte[CMD_SHIFT_DIR_BIT]) begin
              shift_next = (shift_reg == 7'h00) ? 7'(lineLen - 7'h01) : 7'(shift_reg - 7'h01);
            end else begin
              shift_next = (shift_reg >= 7'(lineLen - 7'h01)) ? 7'h00 : 7'(shift_reg + 7'h01);
            end
            opState_next = OP_HOLD;
          end else begin
            opState_next = OP_HOLD;
          end
        end else if (byteDone && latchedRs_reg && !latchedRw_reg) begin
          dataReg_next = hostByte;
          busy_next = 1'b1;
          opState_next = OP_WRITE;
        end else if (byteDone && latchedRs_reg && latchedRw_reg) begin
          busy_next = 1'b1;
          ac_next = stepAc(ac_reg, selPattern_reg, decrementMode, twoLine);
          opState_next = OP_FETCH;
        end
      end
      OP_WRITE: begin
        dispWe = !selPattern_reg;
        patWe = selPattern_reg;
        ac_next = stepAc(ac_reg, selPattern_reg, decrementMode, twoLine);
        opState_next = OP_HOLD;
      end
      OP_FETCH: begin
        opState_next = OP_CAPTURE;
      end
      OP_CAPTURE: begin
        dataReg_next = selPattern_reg ? patRdA : dispRdA;
        opState_next = OP_HOLD;
      end
      OP_CLEAR: begin
        dispWe = 1'b1;
        dispAddrA = clearIdx_reg;
        memWdata = BLANK_CODE;
        if (clearIdx_reg == LAST_PHYS) begin
          ac_next = 7'h00;
          selPattern_next = 1'b0;
          shift_next = 7'h00;
          opState_next = OP_HOLD;
        end else begin
          clearIdx_next = clearIdx_reg + 7'h01;
        end
      end
      OP_HOLD: begin
        if (hold_reg == HOLD_W'(BUSY_HOLD_CYCLES - 1)) begin
          hold_next = '0;
          busy_next = 1'b0;
          opState_next = OP_IDLE;
        end else begin
          hold_next = hold_reg + 1'b1;
        end
      end
      default: begin
        opState_next = OP_IDLE;
      end
    endcase
  end

  // host read drive; the lower lanes stay undriven on a 4-bit bus
  always_comb begin
    dataOut_next = 8'h00;
    dataOe_next = 8'h00;
    if (pinSync2_reg.enable && pinSync2_reg.readWrite) begin
      if (fourBitBus) begin
        dataOut_next = nibblePhase_reg ? {readValue[3:0], 4'h0} : {readValue[7:4], 4'h0};
        dataOe_next = 8'hf0;
      end else begin
        dataOut_next = readValue;
        dataOe_next = 8'hff;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      latchedRs_reg <= 1'b0;
      latchedRw_reg <= 1'b0;
      latchedData_reg <= 8'h00;
      nibblePhase_reg <= 1'b0;
      nibbleHigh_reg <= 4'h0;
      opState_reg <= OP_IDLE;
      busy_reg <= 1'b0;
      ac_reg <= 7'h00;
      selPattern_reg <= 1'b0;
      dataReg_reg <= 8'h00;
      cmdReg_reg <= 8'h00;
      shift_reg <= 7'h00;
      clearIdx_reg <= 7'h00;
      hold_reg <= '0;
      dataOut <= 8'h00;
      dataOe <= 8'h00;
    end else begin
      latchedRs_reg <= latchedRs_next;
      latchedRw_reg <= latchedRw_next;
      latchedData_reg <= latchedData_next;
      nibblePhase_reg <= nibblePhase_next;
      nibbleHigh_reg <= nibbleHigh_next;
      opState_reg <= opState_next;
      busy_reg <= busy_next;
      ac_reg <= ac_next;
      selPattern_reg <= selPattern_next;
      dataReg_reg <= dataReg_next;
      cmdReg_reg <= cmdReg_next;
      shift_reg <= shift_next;
      clearIdx_reg <= clearIdx_next;
      hold_reg <= hold_next;
      dataOut <= dataOut_next;
      dataOe <= dataOe_next;
    end
  end

  // scan: screen position to display address, then code to dots
  always_comb begin
    scanSum = {1'b0, scanCol} + {1'b0, shift_reg};
    scanPos = (scanSum >= {1'b0, lineLen}) ? 7'(scanSum - {1'b0, lineLen}) : scanSum[6:0];
    scanAddr = (twoLine && scanLine) ? 7'(scanPos + LINE2_PHYS_BASE) : scanPos;
    patAddrB = tallFont ? {dispRdB[2:1], scanRow1_reg} : {dispRdB[2:0], scanRow1_reg[2:0]};
    romAddrB = {dispRdB, scanRow1_reg[2:0]};
    codeIsPat2_next = (dispRdB & PATTERN_CODE_MASK) == PATTERN_CODE_VAL;
    dotRow_next = codeIsPat2_reg ? patRdB[DOT_W-1:0] : romRdB[DOT_W-1:0];
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      scanRow1_reg <= 4'h0;
      codeIsPat2_reg <= 1'b0;
      dotRow <= '0;
    end else begin
      scanRow1_reg <= scanRow;
      codeIsPat2_reg <= codeIsPat2_next;
      dotRow <= dotRow_next;
    end
  end

  lcd_ram #(.WIDTH(DATA_W), .DEPTH(DISPLAY_DEPTH), .AW(DISPLAY_AW)) displayRam (
    .clk_sys(clk_sys), .weA(dispWe), .addrA(dispAddrA), .wdataA(memWdata),
    .rdataA(dispRdA), .addrB(scanAddr), .rdataB(dispRdB)
  );

  lcd_ram #(.WIDTH(DATA_W), .DEPTH(PATTERN_DEPTH), .AW(PATTERN_AW)) patternRam (
    .clk_sys(clk_sys), .weA(patWe), .addrA(ac_reg[PATTERN_AW-1:0]), .wdataA(memWdata),
    .rdataA(patRdA), .addrB(patAddrB), .rdataB(patRdB)
  );

  // mask content stands in as a load port; 192 patterns fit the 2048 words
  lcd_ram #(.WIDTH(DATA_W), .DEPTH(ROM_DEPTH), .AW(ROM_AW)) patternRom (
    .clk_sys(clk_sys), .weA(romLoadWe), .addrA(romLoadAddr), .wdataA(romLoadData),
    .rdataA(), .addrB(romAddrB), .rdataB(romRdB)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_fetch;
    opState_reg == OP_FETCH ##1 opState_reg == OP_CAPTURE;
  endsequence

  sequence s_read_done;
    opState_reg == OP_IDLE && byteDone && latchedRs_reg && latchedRw_reg;
  endsequence

  a_busy_on_accept: assert property (opState_reg == OP_IDLE && byteDone && !(latchedRs_reg && !latchedRw_reg && 1'b0)
    && !(latchedRw_reg && !latchedRs_reg) |=> busy_reg) else $error("busy not set on accept");
  a_refuse_busy: assert property (opState_reg != OP_IDLE && byteDone |=> $stable(cmdReg_reg))
    else $error("command taken while busy");
  a_status_bits: assert property (pinSync2_reg.enable && pinSync2_reg.readWrite && !pinSync2_reg.regSelect && !fourBitBus
    |=> dataOut == {$past(busy_reg), $past(ac_reg)} && dataOe == 8'hff) else $error("status read wrong");
  a_four_bit_lanes: assert property (fourBitBus |=> dataOe[3:0] == 4'h0 && dataOut[3:0] == 4'h0)
    else $error("low lanes driven on 4-bit bus");
  a_read_fetch: assert property (s_read_done |=> s_fetch ##1 dataReg_reg == (selPattern_reg ? $past(patRdA) : $past(dispRdA)))
    else $error("next byte not fetched after read");
  a_addr_set: assert property (opState_reg == OP_IDLE && byteDone && !latchedRs_reg && !latchedRw_reg
    && hostByte[CMD_DISP_ADDR_BIT] |=> ac_reg == $past(hostByte[6:0]) && !selPattern_reg ##0 s_fetch)
    else $error("address command not applied");
  a_write_step: assert property (opState_reg == OP_WRITE |=> ac_reg == stepAc($past(ac_reg), selPattern_reg,
    $past(decrementMode), $past(twoLine))) else $error("counter not stepped");
  a_busy_ends: assert property ($rose(busy_reg) |-> ##[1:100] !busy_reg)
    else $error("busy never cleared");
  a_sel_holds: assert property (opState_reg != OP_IDLE && opState_reg != OP_CLEAR |=> $stable(selPattern_reg)
    || $past(opState_reg) == OP_IDLE) else $error("RAM choice changed");
  a_line_wrap: assert property (opState_reg == OP_WRITE && twoLine && !selPattern_reg && !decrementMode
    && ac_reg == LINE1_END_TWO |=> ac_reg == LINE2_START) else $error("line two not reached");

endmodule : lcd_host_register_access

/* File: include/lcd_pkg.sv */
/*
  Shared constants and types for the display controller host port:
  memory sizes, address map of the display lines, instruction codes,
  busy timing and the host pin bundle.
  Assumes a single system clock and synchronous active-low reset.
*/
package lcd_pkg;

  localparam int DATA_W = 8;
  localparam int AC_W = 7;
  localparam int DISPLAY_DEPTH = 80;
  localparam int DISPLAY_AW = 7;
  localparam int PATTERN_DEPTH = 64;
  localparam int PATTERN_AW = 6;
  localparam int ROM_DEPTH = 2048;
  localparam int ROM_AW = 11;
  localparam int DOT_W = 5;

  // display address map (address counter values, line lengths, physical RAM addresses)
  localparam logic [6:0] LINE1_END_ONE = 7'h4f;
  localparam logic [6:0] LINE1_END_TWO = 7'h27;
  localparam logic [6:0] LINE2_START = 7'h40;
  localparam logic [6:0] LINE2_END = 7'h67;
  localparam logic [6:0] LINE_LEN_ONE = 7'h50;
  localparam logic [6:0] LINE_LEN_TWO = 7'h28;
  localparam logic [6:0] LINE2_PHYS_BASE = 7'h28;
  localparam logic [6:0] LAST_PHYS = 7'h4f;

  // instruction decode
  localparam logic [7:0] CMD_CLEAR = 8'h01;
  localparam logic [7:0] CMD_SHIFT_MASK = 8'hf8;
  localparam logic [7:0] CMD_SHIFT_CODE = 8'h18;
  localparam int CMD_SHIFT_DIR_BIT = 2;
  localparam int CMD_DISP_ADDR_BIT = 7;
  localparam logic [7:0] CMD_PAT_ADDR_MASK = 8'hc0;
  localparam logic [7:0] CMD_PAT_ADDR_CODE = 8'h40;

  localparam logic [7:0] BLANK_CODE = 8'h20;
  localparam logic [7:0] PATTERN_CODE_MASK = 8'hf0;
  localparam logic [7:0] PATTERN_CODE_VAL = 8'h00;
  localparam int BUSY_BIT = 7;

  // busy tail after each internal operation, in clk_sys cycles
  localparam int BUSY_HOLD_CYCLES = 4;
  localparam int HOLD_W = 3;

  typedef struct packed {
    logic regSelect;
    logic readWrite;
    logic enable;
    logic [7:0] data;
  } host_pins_t;

  typedef enum logic [2:0] {
    OP_IDLE,
    OP_WRITE,
    OP_FETCH,
    OP_CAPTURE,
    OP_CLEAR,
    OP_HOLD
  } op_state_t;

endpackage : lcd_pkg

/* File: hdl/lcd_ram.sv */
/*
  Small memory with one read/write port and one read-only port.
  Both read data come out of registers, one cycle after the address.
  Writes outside DEPTH are simply dropped, and reads there return zero.
*/
`timescale 1ns/100ps
module lcd_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 80,
  parameter int AW = 7
) (
  // clock
  input wire logic clk_sys,
  // port a
  input wire logic weA,
  input wire logic [AW-1:0] addrA,
  input wire logic [WIDTH-1:0] wdataA,
  output logic [WIDTH-1:0] rdataA,
  // port b
  input wire logic [AW-1:0] addrB,
  output logic [WIDTH-1:0] rdataB
);

  logic [WIDTH-1:0] mem [DEPTH];

  // no reset on the array: content is undefined until written
  always_ff @(posedge clk_sys) begin
    if (weA && (int'(addrA) < DEPTH)) begin
      mem[addrA] <= wdataA;
    end
    rdataA <= (int'(addrA) < DEPTH) ? mem[addrA] : '0;
    rdataB <= (int'(addrB) < DEPTH) ? mem[addrB] : '0;
  end

endmodule : lcd_ram

/* File: testbench/lcd_host_model.sv */
/*
  Host microprocessor model for the display controller host port:
  strobed register reads and writes on an 8- or 4-bit data bus.
  Assumes the device answers within five clk_sys cycles of a strobe rise.
*/
`timescale 1ns/100ps
module lcd_host_model
  import lcd_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // bus mode
  input wire logic fourBitBus,
  // device side of the bus
  input wire logic [7:0] dataOut,
  input wire logic [7:0] dataOe,
  output host_pins_t hostPins
);
  logic rs = 1'b0;
  logic rw = 1'b0;
  logic en = 1'b0;
  logic [7:0] drv = 8'h00;

  // wire level: device lanes win where enabled
  assign hostPins = {rs, rw, en, (dataOe & dataOut) | (~dataOe & drv)};

  task automatic strobe(input logic r, input logic w, input logic [7:0] d,
                        output logic [7:0] q, output logic [7:0] oe);
    @(posedge clk_sys);
    rs <= r;
    rw <= w;
    // released lanes move away from the last value, never hold it
    drv <= w ? ~drv : d;
    @(posedge clk_sys);
    en <= 1'b1;
    repeat (5) @(posedge clk_sys);
    #1;
    q = dataOut;
    oe = dataOe;
    @(posedge clk_sys);
    en <= 1'b0;
    repeat (5) @(posedge clk_sys);
    drv <= ~drv;
  endtask : strobe

  task automatic xfer(input logic r, input logic w, input logic [7:0] d,
                      output logic [7:0] q, output logic [7:0] oe);
    logic [7:0] q1;
    logic [7:0] o1;
    if (fourBitBus) begin
      // low lanes carry junk, high nibble goes first
      strobe(r, w, {d[7:4], ~d[3:0]}, q1, o1);
      strobe(r, w, {d[3:0], d[7:4]}, q, oe);
      q = {q1[7:4], q[7:4]};
    end else begin
      strobe(r, w, d, q, oe);
    end
  endtask : xfer

  task automatic wait_ready(output logic [7:0] st);
    logic [7:0] oe;
    for (int i = 0; i < 200; i++) begin
      xfer(1'b0, 1'b1, 8'h00, st, oe);
      if (st[7] === 1'b0) return;
    end
  endtask : wait_ready
endmodule : lcd_host_model

/* File: testbench/lcd_host_register_access_tb.sv */
/*
  Self-checking bench for the display controller host port: register
  sequences through the host model, dot scan and pattern ROM loading.
  Assumes the host model and the design share clk_sys.
*/
`timescale 1ns/100ps
module lcd_host_register_access_tb;
  import lcd_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic fourBitBus = 1'b0;
  logic twoLine = 1'b0;
  logic decrementMode = 1'b0;
  logic tallFont = 1'b0;
  logic scanLine = 1'b0;
  logic [6:0] scanCol = 7'h00;
  logic [3:0] scanRow = 4'h0;
  logic romLoadWe = 1'b0;
  logic [ROM_AW-1:0] romLoadAddr = 11'h000;
  logic [7:0] romLoadData = 8'h00;
  host_pins_t hostPins;
  logic [7:0] dataOut;
  logic [7:0] dataOe;
  logic [DOT_W-1:0] dotRow;
  logic [7:0] q;
  logic [7:0] oe;
  int nFail = 0;
  int checkCount = 0;
  int cycles = 0;

  lcd_host_register_access lcd_host_register_access_inst (
    .clk_sys(clk_sys), .nrst(nrst), .hostPins(hostPins), .dataOut(dataOut), .dataOe(dataOe),
    .fourBitBus(fourBitBus), .twoLine(twoLine), .decrementMode(decrementMode), .tallFont(tallFont),
    .scanLine(scanLine), .scanCol(scanCol), .scanRow(scanRow), .dotRow(dotRow),
    .romLoadWe(romLoadWe), .romLoadAddr(romLoadAddr), .romLoadData(romLoadData));

  lcd_host_model lcd_host_model_inst (
    .clk_sys(clk_sys), .fourBitBus(fourBitBus), .dataOut(dataOut), .dataOe(dataOe),
    .hostPins(hostPins));

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  // far above the 1300 or so cycles the tests need
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      nFail++;
      complete_run();
    end
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp) begin
      nFail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_dots(input logic [DOT_W-1:0] got, input logic [DOT_W-1:0] exp);
    checkCount++;
    if (got !== exp) begin
      nFail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_dots

  task automatic do_reset;
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
  endtask : do_reset

  // a poll limit that runs out ends the run as a mismatch
  task automatic ready(output logic [7:0] st);
    lcd_host_model_inst.wait_ready(st);
    if (st[7] !== 1'b0) begin
      nFail++;
      complete_run();
    end
  endtask : ready

  task automatic cmd(input logic [7:0] d);
    logic [7:0] st;
    logic [7:0] o;
    ready(st);
    lcd_host_model_inst.xfer(1'b0, 1'b0, d, st, o);
  endtask : cmd

  task automatic wr(input logic [7:0] d);
    logic [7:0] st;
    logic [7:0] o;
    ready(st);
    lcd_host_model_inst.xfer(1'b1, 1'b0, d, st, o);
  endtask : wr

  task automatic rd(output logic [7:0] d, output logic [7:0] o);
    logic [7:0] st;
    ready(st);
    lcd_host_model_inst.xfer(1'b1, 1'b1, 8'h00, d, o);
  endtask : rd

  task automatic status(output logic [7:0] st);
    logic [7:0] o;
    lcd_host_model_inst.xfer(1'b0, 1'b1, 8'h00, st, o);
  endtask : status

  task automatic scan(input logic ln, input logic [6:0] col, input logic [3:0] row, output logic [4:0] dots);
    @(posedge clk_sys);
    scanLine <= ln;
    scanCol <= col;
    scanRow <= row;
    repeat (4) @(posedge clk_sys);
    #1;
    dots = dotRow;
    // hand back on an edge so later input changes stay edge-aligned
    @(posedge clk_sys);
  endtask : scan

  initial begin
    logic [4:0] dots;
    do_reset();
    status(q);
    chk_byte(q, 8'h00);
    $display("test reset status done");
    cmd(8'h85);
    wr(8'ha1);
    wr(8'hb2);
    wr(8'hc3);
    lcd_host_model_inst.wait_ready(q);
    chk_byte(q, 8'h08);
    cmd(8'h85);
    rd(q, oe);
    chk_byte(q, 8'ha1);
    chk_byte(oe, 8'hff);
    rd(q, oe);
    chk_byte(q, 8'hb2);
    rd(q, oe);
    chk_byte(q, 8'hc3);
    lcd_host_model_inst.wait_ready(q);
    chk_byte(q, 8'h08);
    $display("test display access done");
    decrementMode <= 1'b1;
    cmd(8'h90);
    wr(8'h11);
    wr(8'h22);
    lcd_host_model_inst.wait_ready(q);
    chk_byte(q, 8'h0e);
    cmd(8'h8f);
    rd(q, oe);
    chk_byte(q, 8'h22);
    decrementMode <= 1'b0;
    $display("test decrement done");
    cmd(8'h53);
    wr(8'h0a);
    wr(8'h15);
    cmd(8'h53);
    rd(q, oe);
    chk_byte(q, 8'h0a);
    rd(q, oe);
    chk_byte(q, 8'h15);
    cmd(8'h85);
    rd(q, oe);
    chk_byte(q, 8'ha1);
    cmd(8'h80);
    wr(8'h02);
    scan(1'b0, 7'h00, 4'h3, dots);
    chk_dots(dots, 5'h0a);
    $display("test pattern ram done");
    // row 7 of every loaded character kept blank for the cursor
    for (int r = 0; r < 8; r++) begin
      @(posedge clk_sys);
      romLoadWe <= 1'b1;
      romLoadAddr <= {8'h41, r[2:0]};
      romLoadData <= (r == 2) ? 8'he5 : 8'h00;
    end
    @(posedge clk_sys);
    romLoadWe <= 1'b0;
    twoLine <= 1'b1;
    cmd(8'hc0);
    wr(8'h41);
    scan(1'b1, 7'h00, 4'h2, dots);
    chk_dots(dots, 5'h05);
    scan(1'b1, 7'h00, 4'h7, dots);
    chk_dots(dots, 5'h00);
    cmd(8'ha7);
    wr(8'h33);
    lcd_host_model_inst.wait_ready(q);
    chk_byte(q, 8'h40);
    cmd(8'h18);
    scan(1'b1, 7'h27, 4'h2, dots);
    chk_dots(dots, 5'h05);
    twoLine <= 1'b0;
    $display("test pattern rom done");
    cmd(8'h01);
    status(q);
    chk_byte(q & 8'h80, 8'h80);
    lcd_host_model_inst.xfer(1'b1, 1'b0, 8'h77, q, oe);
    lcd_host_model_inst.wait_ready(q);
    chk_byte(q, 8'h00);
    cmd(8'h80);
    rd(q, oe);
    chk_byte(q, BLANK_CODE);
    $display("test clear and busy done");
    fourBitBus <= 1'b1;
    do_reset();
    cmd(8'h8a);
    wr(8'h5c);
    cmd(8'h8a);
    rd(q, oe);
    chk_byte(q, 8'h5c);
    chk_byte(oe, 8'hf0);
    lcd_host_model_inst.wait_ready(q);
    chk_byte(q, 8'h0b);
    $display("test four bit bus done");
    complete_run();
  end
endmodule : lcd_host_register_access_tb
